// ===== dcr_defs.svh
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCR_ADDR_LOOP_CMD   4'h0
`define DCR_ADDR_LOOP_STAT  4'h1

// ----------------------------------------------------------------
// loop command field, bits 7..5 of a command write
// ----------------------------------------------------------------
`define DCR_CMD_MSB         7
`define DCR_CMD_LSB         5
`define DCR_CMD_NULL        3'h0
`define DCR_CMD_SEARCH      3'h1
`define DCR_CMD_RST_MISS    3'h2
`define DCR_CMD_DISABLE     3'h3
`define DCR_CMD_SRC_BAUD    3'h4
`define DCR_CMD_SRC_PIN     3'h5
`define DCR_CMD_MODE_FM     3'h6
`define DCR_CMD_MODE_NRZI   3'h7

// ----------------------------------------------------------------
// loop status bit positions
// ----------------------------------------------------------------
`define DCR_STAT_ENABLED    0
`define DCR_STAT_SEARCH     1
`define DCR_STAT_FM         2
`define DCR_STAT_SRC_BAUD   3
`define DCR_STAT_ONE_MISS   6
`define DCR_STAT_TWO_MISS   7

// ----------------------------------------------------------------
// counter marks; a position is count * 2 + half
// ----------------------------------------------------------------
`define DCR_CNT_REST        5'h10
`define DCR_CNT_LAST        5'h1f
`define DCR_CNT_ADJ         5'h05
`define DCR_CNT_SKIP_FROM   5'h04
`define DCR_CNT_SKIP_TO     5'h06
`define DCR_CNT_DECIDE      5'h02
`define DCR_POS_DEAD_LO     6'h1f
`define DCR_POS_DEAD_HI     6'h20
`define DCR_POS_FM_LATE_HI  6'h26
`define DCR_POS_FM_EARLY_LO 6'h19

`endif

// ===== dcr_pkg.sv
`default_nettype none

package dcr_pkg;

  typedef enum logic [2:0]
  {
    DCR_OFF    = 3'b001,
    DCR_SEARCH = 3'b010,
    DCR_TRACK  = 3'b100
  } dcr_state_t;

  typedef enum logic [1:0]
  {
    DCR_ADJ_NONE  = 2'h0,
    DCR_ADJ_LONG  = 2'h1,
    DCR_ADJ_SHORT = 2'h2
  } dcr_adj_t;

  typedef struct packed
  {
    logic [4:0] cnt;
    logic       half;
  } dcr_phase_t;

  typedef struct packed
  {
    logic fmMode;
    logic srcBaud;
  } dcr_cfg_t;

  typedef struct packed
  {
    logic twoMissed;
    logic oneMissed;
  } dcr_flags_t;

endpackage

`default_nettype wire

// ===== dcr_clock_recovery.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defs.svh"

module dcr_clock_recovery #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [DATA_W-1:0] regRdata,
  input  wire logic              baudClk,
  input  wire logic              pinClk,
  input  wire logic              rxData,
  output var  logic              rxClkOut,
  output var  logic              txClkOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dcr_pkg::dcr_state_t state_r,    state_nxt;
  dcr_pkg::dcr_phase_t phase_r,    phase_nxt;
  dcr_pkg::dcr_cfg_t   cfg_r,      cfg_nxt;
  dcr_pkg::dcr_flags_t flags_r,    flags_nxt;
  dcr_pkg::dcr_adj_t   adjPend_r,  adjPend_nxt;
  dcr_pkg::dcr_adj_t   adjAct_r,   adjAct_nxt;
  logic                rep_r,      rep_nxt;
  logic                seen_r,     seen_nxt;
  logic                winHit_r,   winHit_nxt;
  logic                missPrev_r, missPrev_nxt;
  logic                lossPend_r, lossPend_nxt;
  logic                srcPrev_r,  srcPrev_nxt;
  logic                rxPrev_r,   rxPrev_nxt;
  logic [DATA_W-1:0]   rdata_r,    rdata_nxt;
  logic                rxClk_r,    rxClk_nxt;
  logic                txClk_r,    txClk_nxt;

  logic       cmdWr;
  logic [2:0] cmd;
  logic       srcLevel;
  logic       tick;
  logic       dataEdge;
  logic [5:0] pos;
  logic       wrap;
  logic       missed;
  logic       inWindow;
  logic       deadZone;
  logic       early;
  dcr_pkg::dcr_flags_t flagSet;
  dcr_pkg::dcr_flags_t flagClr;

  assign cmdWr = regWr && (regAddr == `DCR_ADDR_LOOP_CMD);
  assign cmd   = regWdata[`DCR_CMD_MSB:`DCR_CMD_LSB];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt    = state_r;
    phase_nxt    = phase_r;
    cfg_nxt      = cfg_r;
    adjPend_nxt  = adjPend_r;
    adjAct_nxt   = adjAct_r;
    rep_nxt      = rep_r;
    seen_nxt     = seen_r;
    winHit_nxt   = winHit_r;
    missPrev_nxt = missPrev_r;
    lossPend_nxt = lossPend_r;
    flagSet      = '0;
    flagClr      = '0;

    // loop clock is the selected source; both its edges make half counts
    srcLevel    = cfg_r.srcBaud ? baudClk : pinClk;
    srcPrev_nxt = srcLevel;
    tick        = srcLevel != srcPrev_r;
    rxPrev_nxt  = tick ? rxData : rxPrev_r;
    dataEdge    = tick && (rxData != rxPrev_r) && (state_r != dcr_pkg::DCR_OFF);

    pos      = {phase_r.cnt, phase_r.half};
    wrap     = tick && phase_r.half && (phase_r.cnt == `DCR_CNT_LAST);
    deadZone = (pos == `DCR_POS_DEAD_LO) || (pos == `DCR_POS_DEAD_HI);
    early    = pos < `DCR_POS_DEAD_LO;
    inWindow = (pos >= `DCR_POS_FM_EARLY_LO) && (pos <= `DCR_POS_FM_LATE_HI);
    missed   = cfg_r.fmMode && !winHit_r;

    unique case (state_r)
      dcr_pkg::DCR_OFF:
      begin
        phase_nxt = '{cnt: `DCR_CNT_REST, half: 1'b0};
      end
      dcr_pkg::DCR_SEARCH:
      begin
        // first edge is taken as the boundary between 15 and 16
        if (dataEdge)
        begin
          state_nxt  = dcr_pkg::DCR_TRACK;
          // starting edge sits in the window, so its partial cycle is no miss
          winHit_nxt = 1'b1;
        end
        phase_nxt = '{cnt: `DCR_CNT_REST, half: 1'b0};
      end
      dcr_pkg::DCR_TRACK:
      begin
        // only the first edge of a cycle outside the dead zone (in FM, inside the window) steers the correction
        if (dataEdge && !seen_r && !deadZone)
        begin
          if (!cfg_r.fmMode)
          begin
            seen_nxt    = 1'b1;
            adjPend_nxt = early ? dcr_pkg::DCR_ADJ_SHORT : dcr_pkg::DCR_ADJ_LONG;
          end
          else if (inWindow)
          begin
            seen_nxt    = 1'b1;
            adjPend_nxt = early ? dcr_pkg::DCR_ADJ_SHORT : dcr_pkg::DCR_ADJ_LONG;
          end
        end
        // outside the window an edge is data, not clock
        if (dataEdge && cfg_r.fmMode && inWindow)
        begin
          winHit_nxt = 1'b1;
        end
        if (dataEdge && cfg_r.fmMode && inWindow && deadZone)
        begin
          seen_nxt = 1'b1;
        end
        if (tick)
        begin
          phase_nxt.half = !phase_r.half;
          if (phase_r.half)
          begin
            if (phase_r.cnt == `DCR_CNT_ADJ && adjAct_r == dcr_pkg::DCR_ADJ_LONG && !rep_r)
            begin
              rep_nxt = 1'b1;
            end
            else if (phase_r.cnt == `DCR_CNT_SKIP_FROM && adjAct_r == dcr_pkg::DCR_ADJ_SHORT)
            begin
              phase_nxt.cnt = `DCR_CNT_SKIP_TO;
            end
            else
            begin
              phase_nxt.cnt = phase_r.cnt + 5'h01;
            end
          end
        end
        if (wrap)
        begin
          // a cycle without an edge hands on no correction
          adjAct_nxt   = seen_nxt ? adjPend_nxt : dcr_pkg::DCR_ADJ_NONE;
          adjPend_nxt  = dcr_pkg::DCR_ADJ_NONE;
          rep_nxt      = 1'b0;
          seen_nxt     = 1'b0;
          winHit_nxt   = 1'b0;
          missPrev_nxt = missed;
          lossPend_nxt = missed && missPrev_r;
          flagSet.oneMissed = missed;
        end
        // deciding at count 2 keeps both outputs low when the clocks stop
        if (tick && !phase_r.half && phase_r.cnt == `DCR_CNT_DECIDE && lossPend_r)
        begin
          flagSet.twoMissed = 1'b1;
          state_nxt    = dcr_pkg::DCR_SEARCH;
          phase_nxt    = '{cnt: `DCR_CNT_REST, half: 1'b0};
          lossPend_nxt = 1'b0;
          missPrev_nxt = 1'b0;
        end
      end
    endcase

    if (cmdWr)
    begin
      unique case (cmd)
        `DCR_CMD_SEARCH:
        begin
          state_nxt = dcr_pkg::DCR_SEARCH;
          flagClr   = '1;
        end
        `DCR_CMD_DISABLE:
        begin
          state_nxt = dcr_pkg::DCR_OFF;
          flagClr   = '1;
        end
        `DCR_CMD_RST_MISS: flagClr = '1;
        `DCR_CMD_SRC_BAUD: cfg_nxt.srcBaud = 1'b1;
        `DCR_CMD_SRC_PIN:  cfg_nxt.srcBaud = 1'b0;
        `DCR_CMD_MODE_FM:   cfg_nxt.fmMode = 1'b1;
        `DCR_CMD_MODE_NRZI: cfg_nxt.fmMode = 1'b0;
        default:
        begin
        end
      endcase
      if (cmd == `DCR_CMD_SEARCH || cmd == `DCR_CMD_DISABLE)
      begin
        phase_nxt    = '{cnt: `DCR_CNT_REST, half: 1'b0};
        adjPend_nxt  = dcr_pkg::DCR_ADJ_NONE;
        adjAct_nxt   = dcr_pkg::DCR_ADJ_NONE;
        rep_nxt      = 1'b0;
        seen_nxt     = 1'b0;
        winHit_nxt   = 1'b0;
        missPrev_nxt = 1'b0;
        lossPend_nxt = 1'b0;
      end
    end

    // a miss in the same cycle as a clear is kept
    flags_nxt = (flags_r & ~flagClr) | flagSet;

    // decoders: NRZI high on 16..31; FM rx high 4..11/20..27, tx 8..15/24..31
    if (cfg_nxt.fmMode)
    begin
      rxClk_nxt = phase_nxt.cnt[3] ^ phase_nxt.cnt[2];
      txClk_nxt = phase_nxt.cnt[3];
    end
    else
    begin
      rxClk_nxt = phase_nxt.cnt[4];
      txClk_nxt = phase_nxt.cnt[4];
    end

    rdata_nxt = '0;
    if (regRd && regAddr == `DCR_ADDR_LOOP_STAT)
    begin
      rdata_nxt[`DCR_STAT_ENABLED]  = state_r != dcr_pkg::DCR_OFF;
      rdata_nxt[`DCR_STAT_SEARCH]   = state_r != dcr_pkg::DCR_TRACK;
      rdata_nxt[`DCR_STAT_FM]       = cfg_r.fmMode;
      rdata_nxt[`DCR_STAT_SRC_BAUD] = cfg_r.srcBaud;
      rdata_nxt[`DCR_STAT_ONE_MISS] = flags_r.oneMissed;
      rdata_nxt[`DCR_STAT_TWO_MISS] = flags_r.twoMissed;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r    <= dcr_pkg::DCR_OFF;
      cfg_r      <= '{fmMode: 1'b0, srcBaud: 1'b0};
      phase_r    <= '{cnt: `DCR_CNT_REST, half: 1'b0};
      flags_r    <= '0;
      adjPend_r  <= dcr_pkg::DCR_ADJ_NONE;
      adjAct_r   <= dcr_pkg::DCR_ADJ_NONE;
      rep_r      <= 1'b0;
      seen_r     <= 1'b0;
      winHit_r   <= 1'b0;
      missPrev_r <= 1'b0;
      lossPend_r <= 1'b0;
      srcPrev_r  <= 1'b0;
      rxPrev_r   <= 1'b0;
      rdata_r    <= '0;
      rxClk_r    <= 1'b1;
      txClk_r    <= 1'b1;
    end
    else
    begin
      state_r    <= state_nxt;
      cfg_r      <= cfg_nxt;
      phase_r    <= phase_nxt;
      flags_r    <= flags_nxt;
      adjPend_r  <= adjPend_nxt;
      adjAct_r   <= adjAct_nxt;
      rep_r      <= rep_nxt;
      seen_r     <= seen_nxt;
      winHit_r   <= winHit_nxt;
      missPrev_r <= missPrev_nxt;
      lossPend_r <= lossPend_nxt;
      srcPrev_r  <= srcPrev_nxt;
      rxPrev_r   <= rxPrev_nxt;
      rdata_r    <= rdata_nxt;
      rxClk_r    <= rxClk_nxt;
      txClk_r    <= txClk_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign rxClkOut = rxClk_r;
  assign txClkOut = txClk_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  src_select_a : assert property (@(posedge clk) disable iff (rst)
    cmdWr && cmd == `DCR_CMD_SRC_BAUD |=> cfg_r.srcBaud)
    else $error("baud source command not taken");

  enter_search_a : assert property (@(posedge clk) disable iff (rst)
    cmdWr && cmd == `DCR_CMD_SEARCH |=> state_r == dcr_pkg::DCR_SEARCH &&
      flags_r == $past(flagSet))
    else $error("search command did not enter search");

  search_hold_a : assert property (@(posedge clk) disable iff (rst)
    state_r == dcr_pkg::DCR_SEARCH && !dataEdge && !cmdWr |=>
      state_r == dcr_pkg::DCR_SEARCH && phase_r.cnt == `DCR_CNT_REST)
    else $error("search left without an edge");

  mode_select_a : assert property (@(posedge clk) disable iff (rst)
    cmdWr && cmd == `DCR_CMD_MODE_FM |=> cfg_r.fmMode ##0 (rxClkOut == 1'b0 || state_r == dcr_pkg::DCR_TRACK))
    else $error("fm mode command not taken");

  reset_default_a : assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> state_r == dcr_pkg::DCR_OFF && !cfg_r.srcBaud && !cfg_r.fmMode && rxClkOut)
    else $error("reset defaults wrong");

  nrzi_same_a : assert property (@(posedge clk) disable iff (rst)
    !cfg_r.fmMode |-> rxClkOut == txClkOut && rxClkOut == phase_r.cnt[4])
    else $error("nrzi outputs differ");

  fm_lag_a : assert property (@(posedge clk) disable iff (rst)
    cfg_r.fmMode && $rose(txClkOut) |-> rxClkOut && $past(rxClkOut))
    else $error("fm transmit output not lagging");

  skip_five_a : assert property (@(posedge clk) disable iff (rst)
    state_r == dcr_pkg::DCR_TRACK && tick && phase_r.half && !cmdWr && !lossPend_r &&
      phase_r.cnt == `DCR_CNT_SKIP_FROM && adjAct_r == dcr_pkg::DCR_ADJ_SHORT
      |=> phase_r.cnt == `DCR_CNT_SKIP_TO)
    else $error("count 5 not skipped");

  nrzi_rest_a : assert property (@(posedge clk) disable iff (rst)
    state_r != dcr_pkg::DCR_TRACK && !cfg_r.fmMode |-> rxClkOut && txClkOut)
    else $error("nrzi rest outputs not high");

  two_missed_a : assert property (@(posedge clk) disable iff (rst)
    $rose(flags_r.twoMissed) && !$past(cmdWr) |->
      state_r == dcr_pkg::DCR_SEARCH && $past(phase_r.cnt) == `DCR_CNT_DECIDE)
    else $error("double miss not handled at count 2");

  fm_rest_a : assert property (@(posedge clk) disable iff (rst)
    state_r != dcr_pkg::DCR_TRACK && cfg_r.fmMode |-> !rxClkOut && !txClkOut)
    else $error("fm rest outputs not low");

  one_missed_a : assert property (@(posedge clk) disable iff (rst)
    state_r == dcr_pkg::DCR_TRACK && cfg_r.fmMode && wrap && !winHit_r |=> flags_r.oneMissed)
    else $error("single miss not latched");

  dead_zone_a : assert property (@(posedge clk) disable iff (rst)
    state_r == dcr_pkg::DCR_TRACK && dataEdge && deadZone && !seen_r |=>
      adjPend_r == dcr_pkg::DCR_ADJ_NONE)
    else $error("dead zone edge caused a correction");

  entry_hit_a : assert property (@(posedge clk) disable iff (rst)
    state_r == dcr_pkg::DCR_SEARCH && dataEdge && !cmdWr |=>
      state_r == dcr_pkg::DCR_TRACK && winHit_r)
    else $error("search exit edge not taken");

endmodule // dcr_clock_recovery

`default_nettype wire

// ===== dcr_line_sender.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_line_sender
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic lineTick,
  input  wire logic lineFlip,
  input  wire logic lineRun,
  output var  logic rxData
);
  logic [4:0] cellCnt;

  // ----------------------------------------------------------------
  // sender: one edge per 32 loop ticks, data edges only when asked
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cellCnt <= 5'h00;
      rxData  <= 1'b0;
    end
    else if (lineTick)
    begin
      if (lineRun)
        cellCnt <= cellCnt + 5'h01;
      // an edge every 32 ticks is two per loop cycle; search locks onto whichever comes first, the other falls at count 0
      if (lineFlip || (lineRun && cellCnt == 5'h1f))
        rxData <= ~rxData;
    end
  end
endmodule // dcr_line_sender

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defs.svh"

module testbench;
  logic       clk;
  logic       rst;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       baudClk;
  logic       pinClk;
  logic       rxData;
  logic       rxClkOut;
  logic       txClkOut;
  logic       lineTick;
  logic       lineFlip;
  logic       lineRun;
  logic       en;
  logic       srch;
  logic       fm;
  logic       sb;
  logic [1:0] miss;
  int         nFail;
  int         cmpCount;
  int         seed;
  int         n;
  int         hi;
  int         expTot[$];
  int         flipAt[$];

  dcr_clock_recovery dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .baudClk(baudClk), .pinClk(pinClk),
    .rxData(rxData), .rxClkOut(rxClkOut), .txClkOut(txClkOut));
  dcr_line_sender line (.clk(clk), .rst(rst), .lineTick(lineTick), .lineFlip(lineFlip),
    .lineRun(lineRun), .rxData(rxData));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic note(input bit bad, input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (bad)
    begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkV(input logic [7:0] g, input logic [7:0] e);
    note(g !== e, 32'(g), 32'(e));
  endtask

  task automatic chk1(input logic g, input logic e);
    note(g !== e, 32'(g), 32'(e));
  endtask

  task automatic chkN(input int g, input int e);
    note(g != e, g, e);
  endtask

  task automatic closeOut();
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [7:0] stat();
    return {miss, 2'b00, sb, fm, srch, en};
  endfunction

  task automatic doReset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    {en, fm, sb, miss} = 5'h00;
    srch = 1'b1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [2:0] c);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= {c, 5'($random(seed))};
    @(posedge clk);
    regWr <= 1'b0;
    if (a == `DCR_ADDR_LOOP_CMD)
    begin
      if (c == `DCR_CMD_SEARCH || c == `DCR_CMD_DISABLE)
        srch = 1'b1;
      if (c inside {`DCR_CMD_SEARCH, `DCR_CMD_RST_MISS, `DCR_CMD_DISABLE})
        miss = 2'b00;
      if (c == `DCR_CMD_SEARCH || c == `DCR_CMD_DISABLE)
        en = (c == `DCR_CMD_SEARCH);
      if (c[2:1] == 2'b10)
        sb = ~c[0];
      if (c[2:1] == 2'b11)
        fm = ~c[0];
    end
    // idle edge so back-to-back writes never re-drive the strobe in one step
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chkV(regRdata, e);
    @(posedge clk);
  endtask

  // one half-count of the loop; alt moves only the unselected source
  task automatic tick1(input bit alt, input bit fl);
    int w;
    w = 2 + ($unsigned($random(seed)) % 4);
    if (sb ^ alt)
      baudClk <= ~baudClk;
    else
      pinClk <= ~pinClk;
    @(posedge clk);
    lineTick <= ~alt;
    lineFlip <= fl;
    @(posedge clk);
    lineTick <= 1'b0;
    lineFlip <= 1'b0;
    repeat (w) @(posedge clk);
  endtask

  task automatic waitLvl(input bit tx, output int k);
    k = 0;
    while ((tx ? txClkOut : rxClkOut) !== 1'b1 && k < 300)
    begin
      tick1(0, 0);
      k++;
    end
  endtask

  // from one rising receive edge to the next, data edge sent at tick f
  task automatic run(input int f, output int h, output int t);
    h = 0;
    t = 0;
    while (rxClkOut === 1'b1 && t < 300)
    begin
      chk1(txClkOut, rxClkOut);
      tick1(0, t == f);
      t++;
      h++;
    end
    while (rxClkOut !== 1'b1 && t < 300)
    begin
      tick1(0, t == f);
      t++;
    end
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    nFail++;
    closeOut();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 86219;
    {rst, regAddr, regWdata, regWr, regRd} = {1'b1, 14'h0000};
    {baudClk, pinClk, lineTick, lineFlip, lineRun} = 5'h00;
    {nFail, cmpCount} = 0;
    doReset();
    rd(`DCR_ADDR_LOOP_STAT, stat());
    chk1(rxClkOut, 1'b1);
    rd(`DCR_ADDR_LOOP_CMD, 8'h00);
    rd(4'h9, 8'h00);
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_SRC_BAUD);
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_NULL);
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_SEARCH);
    rd(`DCR_ADDR_LOOP_STAT, stat());
    repeat (6) tick1(0, 0);
    chk1(rxClkOut, 1'b1);
    rd(`DCR_ADDR_LOOP_STAT, stat());
    tick1(0, 1);
    tick1(0, 0);
    srch = 1'b0;
    rd(`DCR_ADDR_LOOP_STAT, stat());
    repeat (40) tick1(1, 0);
    chk1(rxClkOut, 1'b1);
    wr(4'h9, `DCR_CMD_DISABLE);
    rd(`DCR_ADDR_LOOP_STAT, stat());
    expTot = '{64, 66, 64, 64, 62, 64};
    flipAt = '{-1, 16, -1, 52, -1, -1};
    foreach (expTot[i])
    begin
      run(flipAt[i], hi, n);
      chkN(hi, 32);
      chkN(n, expTot[i]);
    end
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_SEARCH);
    repeat (8) tick1(0, 0);
    rd(`DCR_ADDR_LOOP_STAT, stat());
    chk1(rxClkOut, 1'b1);
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_DISABLE);
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_SRC_PIN);
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_MODE_FM);
    rd(`DCR_ADDR_LOOP_STAT, stat());
    for (int i = 0; i < 4; i++)
    begin
      wr(`DCR_ADDR_LOOP_CMD, i[0] ? `DCR_CMD_MODE_FM : `DCR_CMD_MODE_NRZI);
      repeat (3) @(posedge clk);
      chk1(rxClkOut, ~i[0]);
      chk1(txClkOut, ~i[0]);
    end
    wr(`DCR_ADDR_LOOP_CMD, `DCR_CMD_SEARCH);
    for (int i = 0; i < 2; i++)
    begin
      chk1(txClkOut, 1'b0);
      lineRun <= 1'b1;
      waitLvl(0, n);
      srch = 1'b0;
      waitLvl(1, n);
      chkN(n, 8);
      repeat (64) tick1(0, 0);
      lineRun <= 1'b0;
      rd(`DCR_ADDR_LOOP_STAT, stat());
      repeat (80) tick1(0, 0);
      miss = 2'b01;
      rd(`DCR_ADDR_LOOP_STAT, stat());
      // second miss lands at the wrap, the decision five ticks later at count 2
      repeat (70) tick1(0, 0);
      {miss, srch} = 3'b111;
      rd(`DCR_ADDR_LOOP_STAT, stat());
      chk1(rxClkOut, 1'b0);
      wr(`DCR_ADDR_LOOP_CMD, i[0] ? `DCR_CMD_RST_MISS : `DCR_CMD_SEARCH);
      rd(`DCR_ADDR_LOOP_STAT, stat());
    end
    doReset();
    rd(`DCR_ADDR_LOOP_STAT, stat());
    chk1(rxClkOut, 1'b1);
    closeOut();
  end
endmodule // testbench

`default_nettype wire
